// ### monitor_defs.svh
/*
  timing counts and fixed values of the monitor command interpreter.
  assumes inclusion by bare name from the interpreter module.
*/
`ifndef MONITOR_DEFS_SVH
`define MONITOR_DEFS_SVH
`define OPC_READ 8'h4A
`define OPC_WRITE 8'h49
`define OPC_INDEXED_READ 8'h1A
`define OPC_INDEXED_WRITE 8'h19
`define OPC_STACK_POINTER_READ 8'h0C
`define OPC_RUN 8'h28
`define SEC_BASE 16'hFFF6
`define SEC_COUNT 4'h8
`define NV_BASE 16'h8000
`define SP_RESET 16'h00FF
`define ENTRY_HOLD_CYCLES 5'h18
`define PC_HI_OFS 16'h0005
`define PC_LO_OFS 16'h0006
`endif

// ### monitor_pkg.sv
/*
  types of the monitor command interpreter.
  assumes monitor_defs.svh in the include path.
*/
package monitor_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] addr_t;
endpackage

// ### mon_byte_if.sv
/*
  valid/ready byte channel between the interpreter and its buffer.
  assumes a single clock domain.
*/
`timescale 1ns/1ps
interface mon_byte_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface // mon_byte_if

// ### byte_skid_buffer.sv
/*
  two-entry buffer in the transmit byte path.
  assumes the upstream holds data stable while valid and not ready.
*/
`timescale 1ns/1ps
module byte_skid_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic arst_n,
  mon_byte_if.sink up,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [$clog2(DEPTH)-1:0] wrPtr_r, rdPtr_r;
  logic [$clog2(DEPTH):0] count_r;
  logic push, pop;
  assign up.ready = (count_r != DEPTH[$clog2(DEPTH):0]);
  assign outValid = (count_r != '0);
  assign push = up.valid && up.ready;
  assign pop = outValid && outReady;
  assign outData = mem_r[rdPtr_r];
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wrPtr_r] <= up.data;
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      count_r <= count_r + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
    end
  end
endmodule // byte_skid_buffer

// ### monitor_command_and_security.sv
/*
  monitor-mode command interpreter with its security gate.
  assumes bytes arrive framed on rxValid/rxData and leave on txValid/txData;
  a memory port with single-cycle read data, stack pointer and H value from the cpu.
*/
// Contract
// (RQ1) indexed read returns two bytes after the last address, no operand.
// (RQ2) repeated indexed commands step sequentially through all of memory.
// (RQ3) stack pointer read returns SP+1, high byte first.
// (RQ4) run restores H from stack then returns from interrupt.
// (RQ5) entry performs interrupt stacking then pushes H.
// (RQ6) stacked program counter high at SP+5, low at SP+6.
// (RQ7) host may rewrite stacked registers before run.
// (RQ8) eight received bytes compared against eight stored security bytes.
// (RQ9) host holds select pin low through reset and 24 clocks after.
// (RQ10) device waits for eight security bytes, echoing each.
// (RQ11) on full match every nonvolatile read and fetch is allowed.
// (RQ12) unlock lasts until reset; every reset relocks.
// (RQ13) on mismatch stay in monitor, nonvolatile reads return undefined.
// (RQ14) locked nonvolatile fetch raises illegal-address reset.
// (RQ15) break character sent only after all eight security bytes.
// (RQ16) erased memory means host sends eight all-ones bytes.
// (RQ17) read opcode with high, low address returns the addressed byte.
// (RQ18) write opcode with address and data stores it, returns nothing.
// (RQ19) indexed read starts just after the last accessed address pointer.
// (RQ20) indexed write stores one byte after last address, then advances.
// (RQ21) every command and operand byte is echoed before any result.
`timescale 1ns/1ps
module monitor_command_and_security
  import monitor_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic monitor_select_pin,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic txValid,
  input wire logic txReady,
  output logic [7:0] txData,
  output logic txBreak,
  output logic memReq,
  output logic memWrite,
  output logic [15:0] memAddr,
  output logic [7:0] memWData,
  input wire logic [7:0] memRData,
  input wire logic [15:0] stackPointer,
  input wire logic [7:0] indexHigh,
  input wire logic fetchValid,
  input wire logic [15:0] fetchAddr,
  output logic monitorActive,
  output logic secured,
  output logic stackEntry,
  output logic runRequest,
  output logic illegalAddrReset
);
`include "monitor_defs.svh"
  typedef enum {S_ENTRY, S_STACK, S_SEC, S_BRK, S_CMD, S_AHI, S_ALO, S_DATA, S_RESP1, S_RESP2, S_IDLE} state_t;
  state_t state_r;
  logic [4:0] holdCnt_r;
  logic [3:0] secCnt_r;
  logic match_r, unlocked_r;
  byte_t opcode_r, resp2_r;
  addr_t addr_r, ptr_r;
  mon_byte_if txIf();
  logic echoPend_r;
  byte_t echoData_r;
  logic respPend_r;
  byte_t respData_r;

  function automatic logic isNv(input addr_t a);
    isNv = (a >= `NV_BASE);
  endfunction
  function automatic byte_t guardRead(input addr_t a, input byte_t d, input logic ok);
    guardRead = (isNv(a) && !ok) ? 8'h00 : d;
  endfunction

  // =====================================
  // transmit path
  assign txIf.valid = echoPend_r || respPend_r;
  assign txIf.data = echoPend_r ? echoData_r : respData_r; // [RQ21]
  byte_skid_buffer #(.WIDTH(8), .DEPTH(BUF_DEPTH)) txBuf (
    .clock(clock),
    .arst_n(arst_n),
    .up(txIf.sink),
    .outValid(txValid),
    .outReady(txReady),
    .outData(txData)
  );
  logic txFree;
  assign txFree = !echoPend_r && !respPend_r;
  logic rxTake;
  assign rxTake = rxValid && txFree && state_r inside {S_SEC, S_CMD, S_AHI, S_ALO, S_DATA};

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      echoPend_r <= 1'b0;
      echoData_r <= 8'h00;
    end else if (rxTake) begin
      echoPend_r <= 1'b1; // [RQ10] [RQ21]
      echoData_r <= rxData;
    end else if (txIf.ready) begin
      echoPend_r <= 1'b0;
    end
  end

  // =====================================
  // security
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      secCnt_r <= 4'h0;
      match_r <= 1'b1;
      unlocked_r <= 1'b0; // [RQ12]
    end else if (state_r == S_SEC && rxTake) begin
      secCnt_r <= secCnt_r + 4'h1;
      if (rxData != memRData) begin
        match_r <= 1'b0; // [RQ8] [RQ13]
      end
      if (secCnt_r == `SEC_COUNT - 4'h1) begin
        unlocked_r <= match_r && (rxData == memRData); // [RQ11]
      end
    end
  end
  assign secured = !unlocked_r;
  assign illegalAddrReset = fetchValid && isNv(fetchAddr) && !unlocked_r && monitorActive; // [RQ14]

  // =====================================
  // entry hold count
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      holdCnt_r <= 5'h00;
    end else if (state_r == S_ENTRY && !monitor_select_pin && holdCnt_r != `ENTRY_HOLD_CYCLES) begin
      holdCnt_r <= holdCnt_r + 5'h01;
    end
  end

  // =====================================
  // command sequencer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= S_ENTRY;
      opcode_r <= 8'h00;
      addr_r <= 16'h0000;
      ptr_r <= 16'h0000;
      resp2_r <= 8'h00;
      respPend_r <= 1'b0;
      respData_r <= 8'h00;
    end else begin
      if (respPend_r && !echoPend_r && txIf.ready) begin
        respPend_r <= 1'b0;
      end
      case (state_r)
        S_ENTRY: begin
          if (monitor_select_pin) begin
            state_r <= S_IDLE;
          end else if (holdCnt_r == `ENTRY_HOLD_CYCLES) begin
            state_r <= S_STACK;
          end
        end
        S_STACK: state_r <= S_SEC; // [RQ5]
        S_SEC: begin
          if (rxTake && secCnt_r == `SEC_COUNT - 4'h1) begin
            state_r <= S_BRK;
          end
        end
        S_BRK: begin
          if (txFree) begin
            state_r <= S_CMD; // [RQ15]
          end
        end
        S_CMD: begin
          if (rxTake) begin
            opcode_r <= rxData;
            case (rxData)
              `OPC_READ, `OPC_WRITE: state_r <= S_AHI;
              `OPC_INDEXED_WRITE: state_r <= S_DATA;
              `OPC_INDEXED_READ: begin
                addr_r <= ptr_r + 16'h0001; // [RQ1] [RQ19]
                state_r <= S_RESP1;
              end
              `OPC_STACK_POINTER_READ: begin
                resp2_r <= stackPointer[7:0] + 8'h01;
                addr_r <= stackPointer + 16'h0001;
                state_r <= S_RESP1; // [RQ3]
              end
              `OPC_RUN: state_r <= S_IDLE; // [RQ4]
              default: state_r <= S_CMD;
            endcase
          end
        end
        S_AHI: begin
          if (rxTake) begin
            addr_r[15:8] <= rxData;
            state_r <= S_ALO;
          end
        end
        S_ALO: begin
          if (rxTake) begin
            addr_r[7:0] <= rxData;
            state_r <= (opcode_r == `OPC_WRITE) ? S_DATA : S_RESP1;
          end
        end
        S_DATA: begin
          if (rxTake) begin
            if (opcode_r == `OPC_INDEXED_WRITE) begin
              ptr_r <= ptr_r + 16'h0001; // [RQ20] [RQ2]
            end else begin
              ptr_r <= addr_r; // [RQ18]
            end
            state_r <= S_CMD;
          end
        end
        S_RESP1: begin
          if (!respPend_r || (!echoPend_r && txIf.ready)) begin
            respPend_r <= 1'b1;
            if (opcode_r == `OPC_STACK_POINTER_READ) begin
              respData_r <= addr_r[15:8];
              state_r <= S_RESP2;
            end else begin
              respData_r <= guardRead(addr_r, memRData, unlocked_r); // [RQ17] [RQ13]
              ptr_r <= addr_r;
              addr_r <= addr_r + 16'h0001; // [RQ2]
              state_r <= (opcode_r == `OPC_INDEXED_READ) ? S_RESP2 : S_CMD;
            end
          end
        end
        S_RESP2: begin
          if (!echoPend_r && txIf.ready) begin
            respPend_r <= 1'b1;
            if (opcode_r == `OPC_STACK_POINTER_READ) begin
              respData_r <= resp2_r;
            end else begin
              respData_r <= guardRead(addr_r, memRData, unlocked_r); // [RQ1]
              ptr_r <= addr_r;
            end
            state_r <= S_CMD;
          end
        end
        S_IDLE: state_r <= S_IDLE;
        default: state_r <= S_ENTRY;
      endcase
    end
  end

  // =====================================
  // memory port
  always_comb begin
    memReq = 1'b0;
    memWrite = 1'b0;
    memAddr = addr_r;
    memWData = rxData;
    if (state_r == S_SEC) begin
      memReq = 1'b1;
      memAddr = `SEC_BASE + {12'h000, secCnt_r}; // [RQ8]
    end else if (state_r == S_RESP1 || state_r == S_RESP2) begin
      memReq = (opcode_r != `OPC_STACK_POINTER_READ);
    end else if (state_r == S_DATA && rxTake) begin
      memReq = 1'b1;
      memWrite = 1'b1;
      memAddr = (opcode_r == `OPC_INDEXED_WRITE) ? ptr_r + 16'h0001 : addr_r; // [RQ20] [RQ18]
    end
  end
  assign txBreak = (state_r == S_BRK) && txFree; // [RQ15]
  assign monitorActive = (state_r != S_ENTRY) && (state_r != S_IDLE || opcode_r == `OPC_RUN);
  assign stackEntry = (state_r == S_STACK); // [RQ5] [RQ6]
  assign runRequest = (state_r == S_CMD) && rxTake && (rxData == `OPC_RUN); // [RQ4]
endmodule // monitor_command_and_security

// ### monitor_command_and_security_monitor.sv
/* concurrent checks on the monitor interpreter ports.
   assumes a bind onto the top module, one clock domain. */
`timescale 1ns/1ps
module monitor_command_and_security_monitor (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic [7:0] txData,
  input wire logic txBreak,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [7:0] memWData,
  input wire logic fetchValid,
  input wire logic [15:0] fetchAddr,
  input wire logic secured,
  input wire logic stackEntry,
  input wire logic runRequest,
  input wire logic illegalAddrReset
);
  // ==========
  // byte count and last byte seen
  logic [3:0] rxCnt_r;
  logic [7:0] lastRx_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rxCnt_r <= 4'h0;
    end else if ($rose(rxValid) && rxCnt_r != 4'hF) begin
      rxCnt_r <= rxCnt_r + 4'h1;
    end
  end
  always_ff @(posedge clock) begin
    if (rxValid) begin
      lastRx_r <= rxData;
    end
  end
  sequence s_stall; txValid && !txReady; endsequence
  sequence s_entry; stackEntry ##1 !stackEntry; endsequence
  property p_txHold; s_stall |=> txValid && $stable(txData); endproperty
  property p_brk; txBreak |-> rxCnt_r == 4'h8; endproperty
  property p_open; !secured |=> !secured; endproperty
  property p_lockFetch; secured && fetchValid && fetchAddr >= 16'h8000 |-> illegalAddrReset; endproperty
  property p_openFetch; !secured |-> !illegalAddrReset; endproperty
  property p_run; runRequest |=> lastRx_r == 8'h28; endproperty
  property p_wr; memReq && memWrite |-> memWData == (rxValid ? rxData : lastRx_r); endproperty
  property p_entry; stackEntry |-> s_entry; endproperty
  a_txHold: assert property (p_txHold) else $error("stalled byte changed");
  a_brk: assert property (p_brk) else $error("break not after eighth byte");
  a_open: assert property (p_open) else $error("unlock lost");
  a_lockFetch: assert property (p_lockFetch) else $error("locked fetch allowed");
  a_openFetch: assert property (p_openFetch) else $error("open fetch refused");
  a_run: assert property (p_run) else $error("run without run byte");
  a_wr: assert property (p_wr) else $error("write data wrong");
  a_entry: assert property (p_entry) else $error("entry not a pulse");
endmodule // monitor_command_and_security_monitor

// ### host_model.sv
/* host end of the monitor byte link: one byte per send, collects returns.
   assumes send is called only when the device awaits a byte. */
`timescale 1ns/1ps
module host_model
  import monitor_pkg::*;
(
  input wire logic clock,
  output logic rxValid,
  output byte_t rxData,
  input wire logic txValid,
  output logic txReady,
  input wire logic [7:0] txData
);
  // ==========
  // stall pattern and capture
  logic slow = 1'b0;
  logic [1:0] tick = 2'h0;
  byte_t got[$];
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
  end
  assign txReady = !slow || tick == 2'h3;
  always @(posedge clock) begin
    tick <= tick + 2'h1;
    if (txValid && txReady) got.push_back(txData);
  end
  task automatic send(input byte_t b);
    @(posedge clock);
    #1;
    rxValid = 1'b1;
    rxData = b;
    @(posedge clock);
    #1;
    rxValid = 1'b0;
    rxData = ~b;
  endtask
endmodule // host_model

// ### test_monitor_command_and_security.sv
/* bench of the monitor interpreter: entry, security, commands, relock.
   assumes host_model and the checker compiled first. */
`timescale 1ns/1ps
module test_monitor_command_and_security import monitor_pkg::*;;
  typedef struct {byte_t b[4]; int n; byte_t r[2]; int nr;} row_t;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic fetchValid = 1'b0;
  logic selPin = 1'b0;
  addr_t fetchAddr = 16'h8000;
  addr_t memAddr;
  byte_t memRData, memWData, rxData, txData;
  logic rxValid, txValid, txReady, txBreak, memReq, memWrite, monitorActive, secured, stackEntry, runRequest;
  logic illegalAddrReset;
  byte_t mem [0:65535];
  int brk, runs, stk, since, entryAt;
  int nMismatch = 0;
  int totalChecks = 0;
  row_t rows [10] = '{'{'{8'h49, 8'h00, 8'h80, 8'h5A}, 4, '{8'h00, 8'h00}, 0},
    '{'{8'h4A, 8'h00, 8'h80, 8'h00}, 3, '{8'h5A, 8'h00}, 1}, '{'{8'h1A, 8'h00, 8'h00, 8'h00}, 1, '{8'hBD, 8'hBE}, 2},
    '{'{8'h19, 8'hA5, 8'h00, 8'h00}, 2, '{8'h00, 8'h00}, 0}, '{'{8'h4A, 8'h00, 8'h83, 8'h00}, 3, '{8'hA5, 8'h00}, 1},
    '{'{8'h1A, 8'h00, 8'h00, 8'h00}, 1, '{8'hB8, 8'hB9}, 2}, '{'{8'h0C, 8'h00, 8'h00, 8'h00}, 1, '{8'h01, 8'hF1}, 2},
    '{'{8'h49, 8'h01, 8'hF6, 8'h42}, 4, '{8'h00, 8'h00}, 0}, '{'{8'h4A, 8'h80, 8'h00, 8'h00}, 3, '{8'h3C, 8'h00}, 1},
    '{'{8'h28, 8'h00, 8'h00, 8'h00}, 1, '{8'h00, 8'h00}, 0}};
  monitor_command_and_security monitor_command_and_security_inst (.clock(clock), .arst_n(arst_n),
    .monitor_select_pin(selPin), .rxValid(rxValid), .rxData(rxData), .txValid(txValid), .txReady(txReady),
    .txData(txData), .txBreak(txBreak), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
    .memWData(memWData), .memRData(memRData), .stackPointer(16'h01F0), .indexHigh(8'h00),
    .fetchValid(fetchValid), .fetchAddr(fetchAddr), .monitorActive(monitorActive), .secured(secured),
    .stackEntry(stackEntry), .runRequest(runRequest), .illegalAddrReset(illegalAddrReset));
  host_model host_inst (.clock(clock), .rxValid(rxValid), .rxData(rxData), .txValid(txValid),
    .txReady(txReady), .txData(txData));
  // ==========
  // clock, memory, event counters
  initial begin
    forever #5 clock = ~clock;
  end
  assign memRData = mem[memAddr];
  always @(posedge clock) begin
    if (memReq && memWrite) mem[memAddr] <= memWData;
  end
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      brk <= 0;
      runs <= 0;
      stk <= 0;
      since <= 0;
    end else begin
      brk <= brk + int'(txBreak);
      runs <= runs + int'(runRequest);
      stk <= stk + int'(stackEntry);
      since <= since + 1;
      if (stackEntry) entryAt <= since;
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    totalChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic expectRx(input byte_t exp);
    for (int k = 0; k < 400 && host_inst.got.size() == 0; k++) @(posedge clock);
    chk("txData", {8'h00, exp}, host_inst.got.size() != 0 ? {8'h00, host_inst.got.pop_front()} : 16'hFFFF);
  endtask
  task automatic xact(input row_t r);
    for (int i = 0; i < r.n; i++) begin
      host_inst.send(r.b[i]);
      expectRx(r.b[i]);
    end
    for (int i = 0; i < r.nr; i++) expectRx(r.r[i]);
    cyc(3);
  endtask
  task automatic doReset();
    arst_n = 1'b0;
    host_inst.got.delete();
    cyc(8);
    arst_n = 1'b1;
  endtask
  task automatic enter(input logic good);
    for (int k = 0; k < 300 && stk == 0; k++) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      if (i == 7) chk("earlyBreak", 16'h0, 16'(brk));
      host_inst.send(good ? mem[16'hFFF6 + 16'(i)] : 8'hFF);
      expectRx(good ? mem[16'hFFF6 + 16'(i)] : 8'hFF);
    end
    cyc(20);
    $display("test entry done");
  endtask
  task automatic fetch(input logic exp);
    fetchValid = 1'b1;
    cyc(1);
    chk("illegalAddr", {15'h0, exp}, {15'h0, illegalAddrReset});
    fetchValid = 1'b0;
  endtask
  task automatic endSim();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #200000;
    nMismatch++;
    endSim();
  end
  initial begin
    for (int a = 0; a < 65536; a++) mem[a] = 8'(a) ^ 8'h3C;
    doReset();
    chk("secured", 16'h1, {15'h0, secured});
    enter(1'b1);
    chk("entryDelay", 16'h1, 16'(entryAt >= 24));
    chk("break", 16'h1, 16'(brk));
    chk("secured", 16'h0, {15'h0, secured});
    for (int i = 0; i < 10; i++) begin
      host_inst.slow = i[0];
      xact(rows[i]);
    end
    chk("run", 16'h1, 16'(runs));
    chk("stackedPc", 16'h0042, {8'h00, mem[16'h01F6]});
    chk("active", 16'h1, {15'h0, monitorActive});
    fetch(1'b0);
    $display("test commands done");
    doReset();
    chk("secured", 16'h1, {15'h0, secured});
    enter(1'b0);
    chk("secured", 16'h1, {15'h0, secured});
    chk("active", 16'h1, {15'h0, monitorActive});
    xact('{'{8'h4A, 8'h80, 8'h00, 8'h00}, 3, '{8'h00, 8'h00}, 1});
    fetch(1'b1);
    $display("test locked done");
    selPin = 1'b1;
    doReset();
    cyc(40);
    chk("entryPulses", 16'h0, 16'(stk));
    chk("active", 16'h0, {15'h0, monitorActive});
    $display("test select done");
    endSim();
  end
endmodule // test_monitor_command_and_security
bind monitor_command_and_security monitor_command_and_security_monitor chk_inst (.clock(clock), .arst_n(arst_n),
  .rxValid(rxValid), .rxData(rxData), .txValid(txValid), .txReady(txReady), .txData(txData), .txBreak(txBreak),
  .memReq(memReq), .memWrite(memWrite), .memWData(memWData), .fetchValid(fetchValid), .fetchAddr(fetchAddr),
  .secured(secured), .stackEntry(stackEntry), .runRequest(runRequest), .illegalAddrReset(illegalAddrReset));
